//--- pkg/psc_pkg.sv
package psc_pkg;

  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 6;
  localparam int POS_180 = 5;
  localparam int POS_90 = 4;
  localparam int POS_45 = 3;
  localparam int POS_22P5 = 2;
  localparam int POS_DUMMY_HIGH = 1;
  localparam int POS_DUMMY_LOW = 0;
  localparam int PHASE_BITS = 4;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] WORD_RST = 6'h00;
  localparam logic [3:0] PHASE_RST = 4'h0;
  localparam logic [1:0] SYNC_RST = 2'h0;

  // ----------------------------------------------------------------
  // timing, for reference only: the controller keeps these
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_PERIOD_MIN_NS = 100;
  localparam int SCK_PERIOD_MIN_CYC = (SCK_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_SPACING_MIN_NS = 630;
  localparam int STROBE_SPACING_MIN_CYC = (STROBE_SPACING_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic phase_bit_180;
    logic phase_bit_90;
    logic phase_bit_45;
    logic phase_bit_22p5;
  } psc_phase_s;

  // shared pins: 22.5 bit or strobe, dummy high or clock, dummy low or data
  typedef struct packed {
    logic pin_22p5_or_strobe;
    logic pin_dhigh_or_clock;
    logic pin_dlow_or_data;
  } psc_shared_s;

  typedef enum logic [2:0] {
    PSC_PARALLEL = 3'b001,
    PSC_SHIFT = 3'b010,
    PSC_LATCHED = 3'b100
  } psc_mode_e;

endpackage

//--- core/psc_sync.sv
`timescale 1ns/1ps
module psc_sync
  import psc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic d, // asynchronous level
  output logic q // synchronised level
);

  logic [1:0] stage_reg;

  // two flops; only the second is read outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= SYNC_RST;
    end else begin
      stage_reg <= {stage_reg[0], d};
    end
  end

  assign q = stage_reg[1];

endmodule

//--- core/psc_ctrl.sv
`timescale 1ns/1ps
module psc_ctrl
  import psc_pkg::*;
(
  input wire logic clk, // system clock, 100 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic serial_select, // high serial, low parallel
  input wire logic phase_bit_180, // parallel 180 degree bit
  input wire logic phase_bit_90, // parallel 90 degree bit
  input wire logic phase_bit_45, // parallel 45 degree bit
  input wire psc_shared_s shared_pins, // shared strobe/clock/data pins
  output logic serial_data_out, // daisy-chain output
  output psc_phase_s phase_state, // applied phase bits
  output logic serial_mode // high while serial mode is active
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic sel_s;
  logic p180_s;
  logic p90_s;
  logic p45_s;
  logic sh2_s;
  logic sh1_s;
  logic sh0_s;

  // select first: the meaning of every shared pin hangs on it
  psc_sync u_sel (
    .clk(clk),
    .rst_n(rst_n),
    .d(serial_select),
    .q(sel_s)
  );

  // parallel-only phase bits
  psc_sync u_p180 (
    .clk(clk),
    .rst_n(rst_n),
    .d(phase_bit_180),
    .q(p180_s)
  );

  psc_sync u_p90 (
    .clk(clk),
    .rst_n(rst_n),
    .d(phase_bit_90),
    .q(p90_s)
  );

  psc_sync u_p45 (
    .clk(clk),
    .rst_n(rst_n),
    .d(phase_bit_45),
    .q(p45_s)
  );

  // shared pins take one common latency, so clock and data stay in step
  psc_sync u_sh2 (
    .clk(clk),
    .rst_n(rst_n),
    .d(shared_pins.pin_22p5_or_strobe),
    .q(sh2_s)
  );

  psc_sync u_sh1 (
    .clk(clk),
    .rst_n(rst_n),
    .d(shared_pins.pin_dhigh_or_clock),
    .q(sh1_s)
  );

  psc_sync u_sh0 (
    .clk(clk),
    .rst_n(rst_n),
    .d(shared_pins.pin_dlow_or_data),
    .q(sh0_s)
  );

  // ----------------------------------------------------------------
  // pin roles by mode
  // ----------------------------------------------------------------
  logic latch_strobe;
  logic serial_clock;
  logic serial_data_in;
  logic dummy_bit_high;
  logic dummy_bit_low;

  // serial roles of the shared pins
  assign latch_strobe = sh2_s;
  assign serial_clock = sh1_s;
  assign serial_data_in = sh0_s;

  // parallel roles; the 22.5 bit is read straight from latch_strobe
  assign dummy_bit_high = sh1_s;
  assign dummy_bit_low = sh0_s;

  // ----------------------------------------------------------------
  // edge detection on the synchronised link
  // ----------------------------------------------------------------
  logic sclk_d_reg;
  logic strobe_d_reg;

  // previous clock level; reset low matches the parked idle level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= serial_clock;
    end
  end

  // previous strobe level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_d_reg <= 1'b0;
    end else begin
      strobe_d_reg <= latch_strobe;
    end
  end

  logic sclk_rise;
  logic strobe_rise;

  // clock masked while strobe high, so the word is safe during an update
  assign sclk_rise = sel_s && serial_clock && !sclk_d_reg && !latch_strobe;

  // strobe counts only in serial mode; in parallel it is the 22.5 bit
  assign strobe_rise = sel_s && latch_strobe && !strobe_d_reg;

  // ----------------------------------------------------------------
  // mode tracking
  // ----------------------------------------------------------------
  psc_mode_e mode_reg;
  psc_mode_e mode_next;

  // latched marks that a serial word has been applied at least once
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      PSC_PARALLEL: begin
        if (sel_s) begin
          mode_next = PSC_SHIFT;
        end
      end
      PSC_SHIFT: begin
        if (!sel_s) begin
          mode_next = PSC_PARALLEL;
        end else if (strobe_rise) begin
          mode_next = PSC_LATCHED;
        end
      end
      PSC_LATCHED: begin
        if (!sel_s) begin
          mode_next = PSC_PARALLEL;
        end
      end
      default: begin
        mode_next = PSC_PARALLEL;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= PSC_PARALLEL;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ----------------------------------------------------------------
  // shift register and daisy chain
  // ----------------------------------------------------------------
  logic [5:0] shift_reg;
  logic [5:0] shift_next;

  // msb arrives first, so after six clocks it sits in bit 5;
  // anything beyond six bits pushes the oldest out of the chain end
  always_comb begin
    shift_next = shift_reg;
    if (sclk_rise) begin
      shift_next = {shift_reg[WORD_BITS-2:0], serial_data_in};
    end
  end

  // power-up content carries no meaning; cleared only for a clean start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= WORD_RST;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // ----------------------------------------------------------------
  // phase state
  // ----------------------------------------------------------------
  logic [3:0] latch_reg;
  logic [3:0] latch_next;
  logic [3:0] par_word;

  // parallel pins in weight order, 22.5 bit on the shared strobe pin
  assign par_word = {p180_s, p90_s, p45_s, latch_strobe};

  // applied word: a strobe copies the upper four shift bits, dummies dropped;
  // parallel mode keeps it in step with the pins, so entering serial mode
  // holds the last parallel phase instead of an old serial word
  always_comb begin
    latch_next = latch_reg;
    if (!sel_s) begin
      latch_next = par_word;
    end else if (strobe_rise) begin
      latch_next = shift_reg[POS_180:POS_22P5];
    end
  end

  // no defined power-up word; zero until a strobe or parallel mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= PHASE_RST;
    end else begin
      latch_reg <= latch_next;
    end
  end

  psc_phase_s phase_reg;
  psc_phase_s phase_next;
  logic sdo_reg;
  logic mode_out_reg;

  // outputs registered; parallel path adds one clock after sync,
  // the closest to combinational a registered output can get
  always_comb begin
    phase_next = phase_reg;
    if (!sel_s) begin
      phase_next = par_word;
    end else if (strobe_rise) begin
      phase_next = shift_reg[POS_180:POS_22P5];
    end else if (mode_reg != PSC_PARALLEL) begin
      phase_next = latch_reg;
    end
  end

  // phase state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= PHASE_RST;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ----------------------------------------------------------------
  // serial chain and mode flag
  // ----------------------------------------------------------------
  // chain end: the bit that entered six serial clocks ago
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_reg <= 1'b0;
    end else begin
      sdo_reg <= shift_reg[WORD_BITS-1];
    end
  end

  // mode flag mirrors the synchronised select, not the raw pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_out_reg <= 1'b0;
    end else begin
      mode_out_reg <= sel_s;
    end
  end

  // ----------------------------------------------------------------
  // dummy pins
  // ----------------------------------------------------------------
  // dummy values are accepted and deliberately unused
  logic unused_dummies;
  assign unused_dummies = dummy_bit_high ^ dummy_bit_low;

  // ports come straight from the flops above
  assign phase_state = phase_reg;
  assign serial_data_out = sdo_reg;
  assign serial_mode = mode_out_reg;

endmodule

//--- tb/psc_ctrl_props.sv
`timescale 1ns/1ps
module psc_ctrl_props
  import psc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic serial_select, // mode pin
  input wire logic phase_bit_180, // parallel bit
  input wire logic phase_bit_90, // parallel bit
  input wire logic phase_bit_45, // parallel bit
  input wire psc_shared_s shared_pins, // shared pins
  input wire logic serial_data_out, // chain output
  input wire psc_phase_s phase_state, // applied phase
  input wire logic serial_mode // mode flag
);
  // ----------------------------------------------------------------
  // helper runs and ages
  // ----------------------------------------------------------------
  int up, sh, sl, lo, ok, sa;
  logic ck_q, sb_q, stb, sck;
  assign stb = shared_pins.pin_22p5_or_strobe;
  assign sck = shared_pins.pin_dhigh_or_clock;
  // ages saturate at 9 so they never wrap into a legal window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {up, sh, sl, lo} <= '0;
      {ok, sa} <= {32'd9, 32'd9};
      {ck_q, sb_q} <= 2'h0;
    end else begin
      up <= up + (up < 9);
      sh <= serial_select ? sh + (sh < 9) : 0;
      sl <= !serial_select ? sl + (sl < 9) : 0;
      lo <= (serial_select && !stb) ? lo + (lo < 9) : 0;
      ok <= (sck && !ck_q && serial_select && !stb) ? 0 : ok + (ok < 9);
      sa <= (stb && !sb_q && serial_select) ? 0 : sa + (sa < 9);
      {ck_q, sb_q} <= {sck, stb};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n |-> phase_state == 4'h0 && !serial_mode
    && !serial_data_out) else $error("outputs not cleared in reset");
  mode_track_a: assert property (up >= 4 |-> serial_mode == $past(serial_select, 3))
    else $error("mode flag lags select wrongly");
  mode_change_a: assert property ($changed(serial_mode) && up >= 5 |->
    $past(serial_select, 3) != $past(serial_select, 4)) else $error("mode flag moved alone");
  par_path_a: assert property (sl >= 6 |-> phase_state == {$past(phase_bit_180, 3),
    $past(phase_bit_90, 3), $past(phase_bit_45, 3), $past(stb, 3)}) else $error("parallel bits not applied");
  serial_hold_a: assert property (sh >= 9 && lo >= 6 |-> $stable(phase_state))
    else $error("phase moved without strobe");
  latch_time_a: assert property ($changed(phase_state) && sh >= 9 |-> sa inside {[2:5]})
    else $error("phase changed off strobe");
  shift_time_a: assert property ($changed(serial_data_out) && up >= 9 |-> ok inside {[2:6]})
    else $error("chain output moved off clock");
  par_quiet_a: assert property (sl >= 8 |-> $stable(serial_data_out))
    else $error("chain shifted in parallel mode");
  cover property (sa == 3 && sh >= 9);
  cover property (ok == 4);
  cover property (sl == 9);
endmodule

bind psc_ctrl psc_ctrl_props chk (.clk, .rst_n, .serial_select, .phase_bit_180, .phase_bit_90, .phase_bit_45,
  .shared_pins, .serial_data_out, .phase_state, .serial_mode);

//--- tb/psc_ctrl_host.sv
`timescale 1ns/1ps
module psc_ctrl_host
  import psc_pkg::*;
(
  input wire logic clk, // sets the start of each request
  output logic serial_select, // mode pin
  output logic phase_bit_180, // parallel bit
  output logic phase_bit_90, // parallel bit
  output logic phase_bit_45, // parallel bit
  output psc_shared_s shared_pins // shared pins
);
  // ----------------------------------------------------------------
  // controller model
  // ----------------------------------------------------------------
  // idle in parallel mode, link clock parked low
  initial begin
    serial_select = 1'b0;
    {phase_bit_180, phase_bit_90, phase_bit_45, shared_pins} = 6'h00;
  end
  // dummies always driven firmly, never floated
  task automatic par(input logic [5:0] w);
    @(negedge clk);
    serial_select = 1'b0;
    {phase_bit_180, phase_bit_90, phase_bit_45, shared_pins} = w;
  endtask
  // 125 ns link clock, offset 2 ns so no edge meets the system clock
  task automatic ser(input logic [5:0] w, input logic latch);
    @(negedge clk);
    serial_select = 1'b1;
    // park strobe and clock low: a parallel word may have left them high
    shared_pins.pin_22p5_or_strobe = 1'b0;
    shared_pins.pin_dhigh_or_clock = 1'b0;
    #2;
    for (int i = 5; i >= 0; i--) begin
      shared_pins.pin_dlow_or_data = w[i];
      #62.5 shared_pins.pin_dhigh_or_clock = 1'b1;
      #62.5 shared_pins.pin_dhigh_or_clock = 1'b0;
      shared_pins.pin_dlow_or_data = ~w[i]; // stale after hold: show the inverse
    end
    if (latch) begin
      #62.5 shared_pins.pin_22p5_or_strobe = 1'b1;
      #62.5 shared_pins.pin_22p5_or_strobe = 1'b0;
    end
    #630;
  endtask
  // clocks sent under a high strobe, to probe the mask
  task automatic masked();
    @(negedge clk);
    #2 shared_pins.pin_22p5_or_strobe = 1'b1;
    repeat (3) begin
      shared_pins.pin_dlow_or_data = ~shared_pins.pin_dlow_or_data;
      #62.5 shared_pins.pin_dhigh_or_clock = 1'b1;
      #62.5 shared_pins.pin_dhigh_or_clock = 1'b0;
    end
    #62.5 shared_pins.pin_22p5_or_strobe = 1'b0;
    #630;
  endtask
endmodule

//--- tb/psc_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module psc_ctrl_test
  import psc_pkg::*;
;
  logic clk, rst_n, serial_select, phase_bit_180, phase_bit_90, phase_bit_45, serial_data_out, serial_mode;
  psc_shared_s shared_pins;
  psc_phase_s phase_state;
  int err_total, num_checks;
  // rows: serial flag, word, expected phase
  localparam logic [10:0] ROWS [10] = '{{1'b0, 6'h00, 4'h0}, {1'b0, 6'h07, 4'h1}, {1'b1, 6'h3c, 4'hf},
    {1'b0, 6'h08, 4'h2}, {1'b1, 6'h05, 4'h1}, {1'b0, 6'h12, 4'h4}, {1'b1, 6'h22, 4'h8},
    {1'b0, 6'h21, 4'h8}, {1'b1, 6'h14, 4'h5}, {1'b0, 6'h3f, 4'hf}};
  always #5 clk = ~clk;
  psc_ctrl_host host (.clk, .serial_select, .phase_bit_180, .phase_bit_90, .phase_bit_45, .shared_pins);
  psc_ctrl uut (.clk, .rst_n, .serial_select, .phase_bit_180, .phase_bit_90, .phase_bit_45, .shared_pins,
    .serial_data_out, .phase_state, .serial_mode);
  // ----------------------------------------------------------------
  // verdict
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // a hung run still ends in the verdict
  initial begin
    #200000;
    err_total++;
    conclude();
  end
  // rows first, then chain, hold and mask by hand
  initial begin
    clk = 1'b0;
    rst_n = 1'b1;
    err_total = 0;
    num_checks = 0;
    // a true falling edge after time zero, so no async reset races the start
    #1 rst_n = 1'b0;
    repeat (5) @(posedge clk);
    #1 `CHK({phase_state, serial_mode, serial_data_out}, 6'h00)
    @(negedge clk) rst_n = 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i][10]) host.ser(ROWS[i][9:4], 1'b1);
      else host.par(ROWS[i][9:4]);
      repeat (8) @(negedge clk);
      `CHK(serial_mode, ROWS[i][10])
      `CHK(phase_state, ROWS[i][3:0])
    end
    host.ser(6'h2d, 1'b1);
    `CHK(serial_data_out, 1'b1)
    host.ser(6'h14, 1'b0);
    `CHK(phase_state, 4'hb)
    `CHK(serial_data_out, 1'b0)
    host.masked();
    `CHK(serial_data_out, 1'b0)
    `CHK(phase_state, 4'h5)
    conclude();
  end
endmodule
